// ===== hdl/ocsq_pkg.sv
package ocsq_pkg;

   // ***************************************************************
   // Command codes
   // ***************************************************************
   localparam logic [7:0] CMD_PIN_ROLE   = 8'hd3;
   localparam logic [7:0] CMD_GATING     = 8'hd4;
   localparam logic [7:0] CMD_RANKS      = 8'hd5;
   localparam logic [7:0] CMD_COND_MODE  = 8'hd6;
   localparam logic [7:0] CMD_FREQ_PHASE = 8'hd7;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int PIN_ROLE_BIT   = 0;
   localparam int WAIT_GOOD_BIT  = 0;
   localparam int START_RANK_LSB = 0;
   localparam int STOP_RANK_LSB  = 2;
   localparam int CCM_BIT        = 0;
   localparam int SHARE_FLAG_BIT = 1;
   localparam int CLK_DIV_LSB    = 0;
   localparam int PHASE_LSB      = 2;

   // ***************************************************************
   // Values after reset
   // ***************************************************************
   localparam logic       PIN_ROLE_RST  = 1'h0;
   localparam logic       WAIT_GOOD_RST = 1'h0;
   localparam logic [3:0] RANKS_RST     = 4'h0;
   localparam logic       CCM_RST       = 1'h1;
   localparam logic [1:0] CLK_DIV_RST   = 2'h0;
   // Phase defaults of pages 3..0, five bits each: 00011, 00001, 00010, 00000.
   localparam logic [19:0] PHASE_RST_ALL = 20'h1_8440;

   // ***************************************************************
   // Sequencing and timing
   // ***************************************************************
   localparam logic [1:0] RANK_FIRST = 2'h0;
   localparam logic [1:0] RANK_LAST  = 2'h3;
   // Quarter oscillator steps per undivided switching period.
   localparam logic [5:0] STEPS_PER_PERIOD = 6'h04;
   localparam logic [4:0] STEPS_PER_HALF   = 5'h02;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_STARTING,
      SEQ_ON,
      SEQ_STOPPING
   } ocsq_state_t;

endpackage : ocsq_pkg

// ===== hdl/ocsq_sw_edge.sv
`timescale 1ns/1ps
module ocsq_sw_edge
   import ocsq_pkg::*;
(
   input  wire logic       sys_clk,    // System clock.
   input  wire logic       arst_n,     // Asynchronous reset, active low.
   input  wire logic       clk_en,     // Freezes state while low.
   input  wire logic [4:0] step_cnt,   // Free-running quarter-period step count.
   input  wire logic [1:0] clk_div,    // Divider code.
   input  wire logic [4:0] phase,      // Phase delay in quarter steps.
   input  wire logic       half_shift, // Adds half a switching period.
   output logic            edge_ff     // One-cycle switching edge.
);

   logic [5:0] period_m1;
   logic [4:0] half_steps;
   logic [4:0] offset;
   logic [4:0] diff;
   logic       hit;

   // ***************************************************************
   // Edge decode
   // ***************************************************************
   // The step count wraps at 32, a multiple of every period, so the masked
   // difference repeats cleanly.
   assign period_m1  = (STEPS_PER_PERIOD << clk_div) - 6'h01;
   assign half_steps = half_shift ? (STEPS_PER_HALF << clk_div) : 5'h00;
   assign offset     = phase + half_steps;
   assign diff       = step_cnt - offset;
   assign hit        = (diff & period_m1[4:0]) == 5'h00;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         edge_ff <= 1'b0;
      else if (clk_en)
         edge_ff <= hit;
   end

endmodule : ocsq_sw_edge

// ===== hdl/ocsq_top.sv
// Summary of operation
// - Role bit picks soft-start input or good output.
// - Soft-start role uses pin current, ignores ramp.
// - Good role drives pin with own power-good.
// - Role and mode writes act only after reload.
// - Per-output settings selected by pages zero to three.
// - Global bit: later ranks wait previous power-good.
// - First start rank is never gated.
// - Stop rank bits 3:2, start rank 1:0.
// - Equal ranks start or stop together.
// - Bit 0 selects continuous or mixed conduction.
// - Share flag read-only, seen at master pages.
// - Paired pages; slave copies master, shifted half.
// - Divider code sets frequency divide by 1..8.
// - Phase field delays edge in quarter steps.
// - Phase resets per page to 0,2,1,3.
// - Detected pair sets master share flag.
// - Enable pin starts; release stops, aborting start.
`timescale 1ns/1ps
module ocsq_top
   import ocsq_pkg::*;
#(
   parameter int NUM_OUT = 4                       // Number of outputs, in pairs.
)
(
   input  wire logic                 sys_clk,            // System clock, 20 MHz.
   input  wire logic                 arst_n,             // Asynchronous reset, active low.
   input  wire logic                 clk_en,             // Freezes all state while low.
   input  wire logic                 cmd_valid,          // Command strobe.
   input  wire logic                 cmd_write,          // High for write, low for read.
   input  wire logic [7:0]           cmd_code,           // Command code.
   input  wire logic [7:0]           cmd_page,           // Selected page.
   input  wire logic [7:0]           cmd_wdata,          // Write data byte.
   output logic      [7:0]           rd_data_ff,         // Read data byte.
   output logic                      rd_valid_ff,        // Read data valid pulse.
   input  wire logic                 nvm_valid,          // Stored settings present.
   input  wire logic [NUM_OUT-1:0]   nvm_pin_role,       // Stored role bits.
   input  wire logic [NUM_OUT-1:0]   nvm_ccm,            // Stored conduction bits.
   input  wire logic [NUM_OUT*7-1:0] nvm_freq_phase,     // Stored frequency and phase.
   input  wire logic                 single_enable_mode, // Enable pin drives sequencing.
   input  wire logic                 first_enable_pin,   // Sequence enable pin.
   input  wire logic [NUM_OUT-1:0]   power_good,         // Per-output power-good.
   input  wire logic [NUM_OUT/2-1:0] share_detect,       // Per-pair sharing detected.
   output logic      [NUM_OUT-1:0]   rail_en_ff,         // Per-output regulator enable.
   output logic      [NUM_OUT-1:0]   ss_current_en_ff,   // Soft-start current source on.
   output logic      [NUM_OUT-1:0]   good_indicator_out, // Dual pin output value.
   output logic      [NUM_OUT-1:0]   good_indicator_oe,  // Dual pin output enable.
   output logic      [NUM_OUT-1:0]   ccm_active_ff,      // Continuous conduction active.
   output logic      [NUM_OUT-1:0]   sw_edge             // Per-output switching edge.
);

   localparam int SW = NUM_OUT + 1 + NUM_OUT / 2;

   // ***************************************************************
   // Input synchronisers
   // ***************************************************************
   logic [SW-1:0]        sync1_ff;
   logic [SW-1:0]        sync2_ff;
   logic [NUM_OUT-1:0]   pg_s;
   logic                 en_s;
   logic [NUM_OUT/2-1:0] share_s;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else if (clk_en)
      begin
         sync1_ff <= {share_detect, first_enable_pin, power_good};
         sync2_ff <= sync1_ff;
      end
   end

   assign pg_s    = sync2_ff[NUM_OUT-1:0];
   assign en_s    = sync2_ff[NUM_OUT];
   assign share_s = sync2_ff[SW-1:NUM_OUT+1];

   // ***************************************************************
   // Command decode
   // ***************************************************************
   logic       load_done_ff;
   logic       load_now;
   logic       wr_go;
   logic       rd_go;
   logic [1:0] pidx;
   logic       page_in_range;
   logic       slave_page;
   logic       page_ok;
   logic       wr_gating;
   logic       wr_role_any;

   assign load_now      = !load_done_ff;
   assign wr_go         = cmd_valid && cmd_write && load_done_ff;
   assign rd_go         = cmd_valid && !cmd_write;
   assign pidx          = cmd_page[1:0];
   assign page_in_range = cmd_page < 8'(NUM_OUT);
   assign slave_page    = pidx[0] && share_s[pidx[1]];
   assign page_ok       = page_in_range && !slave_page;
   assign wr_gating     = wr_go && (cmd_code == CMD_GATING);
   assign wr_role_any   = wr_go && (cmd_code == CMD_PIN_ROLE);

   // Settings from storage are taken once, on the first enabled edge
   // after reset, never from the ports under reset itself.
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         load_done_ff <= 1'b0;
      else if (clk_en)
         load_done_ff <= 1'b1;
   end

   // ***************************************************************
   // Global start gating register
   // ***************************************************************
   logic gate_ignore_ff;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         gate_ignore_ff <= WAIT_GOOD_RST;
      else if (clk_en && wr_gating)
         gate_ignore_ff <= cmd_wdata[WAIT_GOOD_BIT];
   end

   // ***************************************************************
   // Per-output settings
   // ***************************************************************
   logic              role_sh_ff [NUM_OUT];
   logic              role_act_ff[NUM_OUT];
   logic              ccm_sh_ff  [NUM_OUT];
   logic              ccm_act_ff [NUM_OUT];
   logic [6:0]        fp_sh_ff   [NUM_OUT];
   logic [6:0]        fp_act_ff  [NUM_OUT];
   logic [3:0]        rank_ff    [NUM_OUT];
   logic [1:0]        src_idx    [NUM_OUT];
   logic [NUM_OUT-1:0] eff_role;
   logic [NUM_OUT-1:0] eff_ccm;
   logic [NUM_OUT-1:0] slave_on;
   logic [NUM_OUT-1:0] start_hit;
   logic [NUM_OUT-1:0] prev_hit;
   logic [NUM_OUT-1:0] stop_hit;
   logic [NUM_OUT-1:0] wr_sel;
   logic [1:0]         rank_ff_cnt;
   logic [4:0]         step_ff;

   genvar i;
   generate
      for (i = 0; i < NUM_OUT; i++)
      begin : g_out
         assign slave_on[i]  = (i % 2 == 1) && share_s[i/2];
         assign src_idx[i]   = slave_on[i] ? 2'(i - 1) : 2'(i);
         assign eff_role[i]  = role_act_ff[src_idx[i]];
         assign eff_ccm[i]   = ccm_act_ff[src_idx[i]];
         assign wr_sel[i]    = wr_go && page_ok && (pidx == 2'(i));
         assign start_hit[i] = rank_ff[src_idx[i]][START_RANK_LSB +: 2] == rank_ff_cnt;
         assign prev_hit[i]  = rank_ff[src_idx[i]][START_RANK_LSB +: 2]
                               == (rank_ff_cnt - 2'h1);
         assign stop_hit[i]  = rank_ff[src_idx[i]][STOP_RANK_LSB +: 2] == rank_ff_cnt;

         always_ff @(posedge sys_clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               role_sh_ff[i]  <= PIN_ROLE_RST;
               role_act_ff[i] <= PIN_ROLE_RST;
               ccm_sh_ff[i]   <= CCM_RST;
               ccm_act_ff[i]  <= CCM_RST;
               fp_sh_ff[i]    <= {PHASE_RST_ALL[i*5 +: 5], CLK_DIV_RST};
               fp_act_ff[i]   <= {PHASE_RST_ALL[i*5 +: 5], CLK_DIV_RST};
            end
            else if (clk_en && load_now && nvm_valid)
            begin
               role_sh_ff[i]  <= nvm_pin_role[i];
               role_act_ff[i] <= nvm_pin_role[i];
               ccm_sh_ff[i]   <= nvm_ccm[i];
               ccm_act_ff[i]  <= nvm_ccm[i];
               fp_sh_ff[i]    <= nvm_freq_phase[i*7 +: 7];
               fp_act_ff[i]   <= nvm_freq_phase[i*7 +: 7];
            end
            else if (clk_en && wr_sel[i])
            begin
               if (cmd_code == CMD_PIN_ROLE)
                  role_sh_ff[i] <= cmd_wdata[PIN_ROLE_BIT];
               if (cmd_code == CMD_COND_MODE)
                  ccm_sh_ff[i] <= cmd_wdata[CCM_BIT];
               if (cmd_code == CMD_FREQ_PHASE)
                  fp_sh_ff[i] <= cmd_wdata[6:0];
            end
         end

         always_ff @(posedge sys_clk or negedge arst_n)
         begin
            if (!arst_n)
               rank_ff[i] <= RANKS_RST;
            else if (clk_en && wr_sel[i] && cmd_code == CMD_RANKS)
               rank_ff[i] <= cmd_wdata[3:0];
         end

         ocsq_sw_edge u_edge (
            .sys_clk    (sys_clk),
            .arst_n     (arst_n),
            .clk_en     (clk_en),
            .step_cnt   (step_ff),
            .clk_div    (fp_act_ff[src_idx[i]][CLK_DIV_LSB +: 2]),
            .phase      (fp_act_ff[src_idx[i]][PHASE_LSB +: 5]),
            .half_shift (slave_on[i]),
            .edge_ff    (sw_edge[i])
         );
      end
   endgenerate

   // ***************************************************************
   // Quarter-period step counter
   // ***************************************************************
   // Each enabled system clock stands for one quarter oscillator period.
   // quarter-step phase base
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         step_ff <= 5'h00;
      else if (clk_en)
         step_ff <= step_ff + 5'h01;
   end

   // ***************************************************************
   // Dual-role pins and conduction mode
   // ***************************************************************
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         good_indicator_out <= '0;
         good_indicator_oe  <= '0;
         ss_current_en_ff   <= '0;
         ccm_active_ff      <= '0;
      end
      else if (clk_en)
      begin
         good_indicator_oe  <= eff_role;
         good_indicator_out <= pg_s & eff_role;
         ss_current_en_ff   <= ~eff_role;
         ccm_active_ff      <= eff_ccm;
      end
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   ocsq_state_t state_ff;
   ocsq_state_t nxt_state;
   logic [1:0]  nxt_rank;
   logic [NUM_OUT-1:0] nxt_rail;
   logic        run_req;
   logic        gate_ok;

   assign run_req = single_enable_mode && en_s;
   assign gate_ok = (rank_ff_cnt == RANK_FIRST) || gate_ignore_ff
                    || ((pg_s | ~prev_hit) == '1);

   always_comb
   begin
      nxt_state = state_ff;
      nxt_rank  = rank_ff_cnt;
      nxt_rail  = rail_en_ff;
      case (state_ff)
         SEQ_IDLE:
            if (run_req)
            begin
               nxt_state = SEQ_STARTING;
               nxt_rank  = RANK_FIRST;
            end
         SEQ_STARTING:
            if (!run_req)
            begin
               nxt_state = SEQ_STOPPING;
               nxt_rank  = RANK_FIRST;
            end
            else if (gate_ok)
            begin
               nxt_rail = rail_en_ff | start_hit;
               if (rank_ff_cnt == RANK_LAST)
                  nxt_state = SEQ_ON;
               else
                  nxt_rank = rank_ff_cnt + 2'h1;
            end
         SEQ_ON:
            if (!run_req)
            begin
               nxt_state = SEQ_STOPPING;
               nxt_rank  = RANK_FIRST;
            end
         SEQ_STOPPING:
         begin
            nxt_rail = rail_en_ff & ~stop_hit;
            if (rank_ff_cnt == RANK_LAST)
               nxt_state = SEQ_IDLE;
            else
               nxt_rank = rank_ff_cnt + 2'h1;
         end
         default:
            nxt_state = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff    <= SEQ_IDLE;
         rank_ff_cnt <= RANK_FIRST;
         rail_en_ff  <= '0;
      end
      else if (clk_en)
      begin
         state_ff    <= nxt_state;
         rank_ff_cnt <= nxt_rank;
         rail_en_ff  <= nxt_rail;
      end
   end

   // ***************************************************************
   // Read-back
   // ***************************************************************
   logic [7:0] rd_word;
   logic       share_flag;

   assign share_flag = !pidx[0] && share_s[pidx[1]];

   always_comb
   begin
      rd_word = 8'h00;
      if (cmd_code == CMD_GATING)
         rd_word = {7'h00, gate_ignore_ff};
      else if (!page_ok)
         rd_word = 8'h00;
      else if (cmd_code == CMD_PIN_ROLE)
         rd_word = {7'h00, role_sh_ff[pidx]};
      else if (cmd_code == CMD_RANKS)
         rd_word = {4'h0, rank_ff[pidx]};
      else if (cmd_code == CMD_COND_MODE)
         rd_word = {6'h00, share_flag, ccm_sh_ff[pidx]};
      else if (cmd_code == CMD_FREQ_PHASE)
         rd_word = {1'b0, fp_sh_ff[pidx]};
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_data_ff  <= 8'h00;
         rd_valid_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         rd_valid_ff <= rd_go;
         if (rd_go)
            rd_data_ff <= rd_word;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   sequence s_start_blocked;
      state_ff == SEQ_STARTING && run_req && !gate_ok;
   endsequence

   sequence s_abort;
      state_ff == SEQ_STARTING && !run_req;
   endsequence

   property p_role_good;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en)
      eff_role[0] |=> good_indicator_oe[0] && !ss_current_en_ff[0];
   endproperty
   a_role_good: assert property (p_role_good)
      else $error("Good role did not enable pin drive.");

   property p_role_ss;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en)
      !eff_role[1] |=> ss_current_en_ff[1] && !good_indicator_oe[1];
   endproperty
   a_role_ss: assert property (p_role_ss)
      else $error("Soft-start role did not enable current source.");

   property p_good_drive;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en)
      good_indicator_oe[2] |-> good_indicator_out[2] == $past(pg_s[2]);
   endproperty
   a_good_drive: assert property (p_good_drive)
      else $error("Pin value differs from its power-good.");

   property p_role_frozen;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en)
      wr_role_any |=> $stable(eff_role) || $changed(share_s);
   endproperty
   a_role_frozen: assert property (p_role_frozen)
      else $error("Role write changed active role.");

   property p_gate_hold;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en)
      s_start_blocked |=> $stable(rail_en_ff) && state_ff == SEQ_STARTING;
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("Start advanced without previous power-good.");

   property p_first_free;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en)
      state_ff == SEQ_STARTING && run_req && rank_ff_cnt == RANK_FIRST
      |=> (rail_en_ff & $past(start_hit)) == $past(start_hit);
   endproperty
   a_first_free: assert property (p_first_free)
      else $error("First rank was gated.");

   property p_abort;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en)
      s_abort |=> state_ff == SEQ_STOPPING && rank_ff_cnt == RANK_FIRST;
   endproperty
   a_abort: assert property (p_abort)
      else $error("Enable release did not abort start.");

   property p_stop_walk;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en)
      state_ff == SEQ_STOPPING && rank_ff_cnt == RANK_FIRST
      |=> rank_ff_cnt == 2'h1 ##1 rank_ff_cnt == 2'h2 ##1 rank_ff_cnt == RANK_LAST
          ##1 state_ff == SEQ_IDLE;
   endproperty
   a_stop_walk: assert property (p_stop_walk)
      else $error("Stop ranks did not walk in order.");

   property p_reserved_zero;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en)
      rd_go && cmd_code == CMD_RANKS |=> rd_valid_ff && rd_data_ff[7:4] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("Reserved rank bits read nonzero.");

endmodule : ocsq_top

// ===== tb/ocsq_host.sv
`timescale 1ns/1ps
// ************************************************
// Host model issuing one command per call
// ************************************************
module ocsq_host (
   input  wire logic       sys_clk,     // System clock.
   input  wire logic       rd_valid_ff, // Read data valid pulse.
   input  wire logic [7:0] rd_data_ff,  // Read data byte.
   output logic            cmd_valid,   // Command strobe.
   output logic            cmd_write,   // Write flag.
   output logic [7:0]      cmd_code,    // Command code.
   output logic [7:0]      cmd_page,    // Page.
   output logic [7:0]      cmd_wdata    // Write byte.
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code  = 8'h00;
      cmd_page  = 8'h00;
      cmd_wdata = 8'h00;
   end
   task automatic xfer(input logic w, input logic [7:0] c, p, d, output logic [7:0] q);
      int k;
      q = 8'hxx;
      @(negedge sys_clk);
      {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = {1'b1, w, c, p, d};
      @(negedge sys_clk);
      // Released lines show a changed pattern so stale values never pass.
      {cmd_valid, cmd_code, cmd_page, cmd_wdata} = {1'b0, ~c, ~p, ~d};
      for (k = 0; k < 3 && !w; k++)
      begin
         if (rd_valid_ff === 1'b1)
         begin
            q = rd_data_ff;
            break;
         end
         @(negedge sys_clk);
      end
   endtask : xfer
endmodule : ocsq_host

// ===== tb/output_sequencing_config_test.sv
`timescale 1ns/1ps
`define CHK(n,e,s) begin cmp_count++; if ((e) !== (s)) begin fails++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
// ************************************************
// Bench with register and sequencing model
// ************************************************
module output_sequencing_config_test;
   import ocsq_pkg::*;
   logic        sys_clk = 0, arst_n = 0, first_enable_pin = 0, single_enable_mode = 0;
   logic        cmd_valid, cmd_write, rd_valid_ff;
   logic [7:0]  cmd_code, cmd_page, cmd_wdata, rd_data_ff, q;
   logic [3:0]  power_good = 0, rails, ss, goe, gio, ccm, swe, er;
   logic [15:0] lf = 16'h2406;
   logic [27:0] nfp = 28'h0;
   logic        nvm_v = 1'b0;
   logic [1:0]  shd = 2'h0;
   int          fails = 0, cmp_count = 0, cyc = 0, m[5][4], ec[4], ph[4];
   int          msk[5] = '{1, 1, 15, 1, 127};
   ocsq_host host_u (.sys_clk, .rd_valid_ff, .rd_data_ff, .cmd_valid, .cmd_write,
      .cmd_code, .cmd_page, .cmd_wdata);
   ocsq_top dut_u (.sys_clk, .arst_n, .clk_en(1'b1), .cmd_valid, .cmd_write, .cmd_code,
      .cmd_page, .cmd_wdata, .rd_data_ff, .rd_valid_ff, .nvm_valid(nvm_v),
      .nvm_pin_role(lf[3:0]), .nvm_ccm(lf[7:4]), .nvm_freq_phase(nfp),
      .single_enable_mode, .first_enable_pin, .power_good, .share_detect(shd),
      .rail_en_ff(rails), .ss_current_en_ff(ss), .good_indicator_out(gio),
      .good_indicator_oe(goe), .ccm_active_ff(ccm), .sw_edge(swe));
   initial forever #25 sys_clk = ~sys_clk;
   function logic [7:0] nx();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[7:0];
   endfunction : nx
   function logic [7:0] exp_rd(int k, int i);
      if (i > 3 && k != 1) return 8'h00;
      return 8'(m[k][k == 1 ? 0 : i]);
   endfunction : exp_rd
   function logic [3:0] exp_rails(logic [3:0] g);
      int r, j, lv, ok;
      lv = 0;
      for (r = 1; r < 4; r++)
      begin
         ok = 1;
         for (j = 0; j < 4; j++) if ((m[2][j] & 3) == r - 1 && !g[j]) ok = m[1][0] & 1;
         if (!ok) break;
         lv = r;
      end
      for (j = 0; j < 4; j++) exp_rails[j] = (m[2][j] & 3) <= lv;
   endfunction : exp_rails
   task close_out;
      $display("counts cmp_count %0d fails %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   // Counts edges per output over 32 cycles and notes the last edge position.
   task count_edges;
      int t, j;
      ec = '{0, 0, 0, 0};
      for (t = 0; t < 32; t++)
      begin
         @(negedge sys_clk);
         for (j = 0; j < 4; j++)
         begin
            ec[j] += swe[j];
            if (swe[j])
               ph[j] = t;
         end
      end
   endtask : count_edges
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         fails++;
         close_out;
      end
   end
   task run(logic [3:0] r, logic [3:0] g);
      power_good = g;
      first_enable_pin = r[0];
      repeat (20) @(negedge sys_clk);
      `CHK("rails", r[0] ? exp_rails(g) : 4'h0, rails)
   endtask : run
   initial
   begin
      int i, k;
      logic [7:0] w;
      foreach (m[k, i]) m[k][i] = k == 3 ? 1 : k == 4 ? ((i >> 1) | ((i & 1) << 1)) << 2 : 0;
      nfp = 28'({nx(), nx(), nx(), nx()});
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk) arst_n = 1;
      repeat (2) @(negedge sys_clk);
      for (k = 0; k < 5; k++) for (i = 0; i < 5; i++)
      begin
         host_u.xfer(1'b0, 8'hd3 + 8'(k), 8'(i), 8'h00, q);
         `CHK("reset read", exp_rd(k, i), q)
      end
      $display("test defaults done");
      for (k = 0; k < 5; k++) for (i = 0; i < 5; i++)
      begin
         w = nx();
         host_u.xfer(1'b1, 8'hd3 + 8'(k), 8'(i), w, q);
         if (i < 4 || k == 1) m[k][k == 1 ? 0 : i] = w & msk[k];
         host_u.xfer(1'b0, 8'hd3 + 8'(k), 8'(i), 8'h00, q);
         `CHK("write read", exp_rd(k, i), q)
      end
      host_u.xfer(1'b0, 8'hd8, 8'h00, 8'h00, q);
      `CHK("unmapped", 8'h00, q)
      `CHK("ss", 4'hf, ss)
      `CHK("oe", 4'h0, goe)
      `CHK("ccm", 4'hf, ccm)
      count_edges;
      for (i = 0; i < 4; i++) `CHK("edges", 8, ec[i])
      for (i = 0; i < 4; i++) `CHK("phase", {i[0], i[1]}, (ph[i] - ph[0] + 4) % 4)
      $display("test registers done");
      for (k = 0; k < 3; k++)
      begin
         host_u.xfer(1'b1, 8'hd4, 8'h00, 8'(k == 1), q);
         m[1][0] = k == 1;
         for (i = 0; i < 4; i++)
         begin
            m[2][i] = k == 2 ? 0 : ((3 - i) << 2) | i;
            host_u.xfer(1'b1, 8'hd5, 8'(i), 8'(m[2][i]), q);
         end
         single_enable_mode = 1'b1;
         if (k == 0) for (i = 0; i < 4; i++) run(4'h1, 4'((1 << i) - 1));
         else run(4'h1, 4'h0);
         run(4'h0, 4'h0);
      end
      $display("test sequencing done");
      // Second reset with stored settings present and pair 0/1 sharing.
      nvm_v = 1'b1;
      shd = 2'h1;
      power_good = lf[11:8];
      arst_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      arst_n = 1'b1;
      er = {lf[3:2], lf[0], lf[0]};
      repeat (6) @(negedge sys_clk);
      `CHK("reload ss", ~er, ss)
      `CHK("reload oe", er, goe)
      `CHK("reload pin", er & power_good, gio)
      `CHK("reload ccm", {lf[7:6], lf[4], lf[4]}, ccm)
      host_u.xfer(1'b0, 8'hd6, 8'h00, 8'h00, q);
      `CHK("share flag", {6'h00, 1'b1, lf[4]}, q)
      host_u.xfer(1'b0, 8'hd6, 8'h01, 8'h00, q);
      `CHK("slave page", 8'h00, q)
      count_edges;
      for (i = 0; i < 4; i++) `CHK("edges2", 8 >> nfp[(i == 1 ? 0 : 7 * i) +: 2], ec[i])
      $display("test reload done");
      close_out;
   end
endmodule : output_sequencing_config_test
